// *** spis_host.sv ***
// two-wire bus master model that writes the sensor registers
`timescale 1ns/1ps
module spis_host
#(
    parameter int HALF_CYC = 5
)
(
    input wire logic clk_sys,
    output logic scl,
    output logic sda_m,
    input wire logic sda_bus
);
    // ****************************************
    // bus primitives
    // ****************************************
    // both lines idle high, nothing driven low
    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // wait a number of system clocks
    task automatic hold(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // data moves one clock after the clock line fell, never with it
    task automatic put_bit(input logic b, output logic seen);
        hold(1);
        sda_m <= b;
        hold(HALF_CYC);
        scl <= 1'b1;
        hold(HALF_CYC);
        seen = sda_bus;
        scl <= 1'b0;
    endtask
    // eight bits then a released acknowledge slot
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--)
            put_bit(v[i], seen);
        put_bit(1'b1, seen);
        ack = !seen;
    endtask
    // start, address and direction, index, data, stop
    task automatic write_reg(input logic [6:0] adr, input logic rd,
        input logic [7:0] idx, input logic [7:0] dat,
        output logic [2:0] acks);
        sda_m <= 1'b0;
        hold(HALF_CYC);
        scl <= 1'b0;
        put_byte({adr, rd}, acks[2]);
        put_byte(idx, acks[1]);
        put_byte(dat, acks[0]);
        hold(1);
        sda_m <= 1'b0;
        hold(HALF_CYC);
        scl <= 1'b1;
        hold(HALF_CYC);
        sda_m <= 1'b1;
        hold(HALF_CYC);
    endtask
endmodule

// *** spis_light_conv.sv ***
// light converter: windowed integration and lux scaling
`timescale 1ns/1ps
module spis_light_conv
#(
    parameter int WINDOW_CYC = spis_pkg::INTEG_CYC
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic enable,
    input wire logic range_high,
    input wire logic photo_pulse,
    output logic [11:0] code_q,
    output logic code_valid_q,
    output logic [27:0] lux_x10k_q
);
    // window counter and charge accumulator
    logic [23:0] win_q;
    logic [11:0] acc_q;
    wire win_end = (win_q == 24'(WINDOW_CYC - 1));
    wire [11:0] acc_inc = (acc_q == 12'hFFF) ? acc_q : acc_q + 12'h001;
    // closing count keeps the last cycle's pulse, so no charge is lost
    wire [11:0] acc_last = photo_pulse ? acc_inc : acc_q;
    wire [15:0] scale = range_high ? spis_pkg::SCALE_HIGH
                                   : spis_pkg::SCALE_LOW;
    wire [27:0] lux_next = 28'(acc_last) * 28'(scale); // lux times 10000
    // ****************************************
    // integration over whole mains periods
    // ****************************************
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            win_q <= 24'h000000;
            acc_q <= 12'h000;
            code_q <= 12'h000;
            code_valid_q <= 1'b0;
            lux_x10k_q <= 28'h0000000;
        end
        else if (!enable)
        begin
            // halted converter restarts its window
            win_q <= 24'h000000;
            acc_q <= 12'h000;
            code_valid_q <= 1'b0;
        end
        else if (win_end)
        begin
            // code linear in illuminance, lux = scale * code
            win_q <= 24'h000000;
            acc_q <= 12'h000;
            code_q <= acc_last;
            code_valid_q <= 1'b1;
            lux_x10k_q <= lux_next;
        end
        else
        begin
            win_q <= win_q + 24'h000001;
            if (photo_pulse)
                acc_q <= acc_inc;
        end
    end
endmodule

// *** spis_pkg.sv ***
// shared constants for the sensor power and init sequencer
package spis_pkg;
    // ****************************************
    // bus addressing
    // ****************************************
    localparam logic [6:0] SLAVE_ADDR = 7'h44; // fixed 1000100
    localparam logic [7:0] REG_CFG1 = 8'h01; // configuration register 1
    localparam logic [7:0] REG_TEST1 = 8'h0E; // test register 1
    localparam logic [7:0] REG_TEST2 = 8'h0F; // test register 2
    // ****************************************
    // configuration register 1 fields
    // ****************************************
    localparam int CFG_RANGE_BIT = 1; // light range select
    localparam int CFG_LIGHT_IR_BIT = 0; // light_ir_select
    localparam int CFG_PROX_EN_BIT = 7; // proximity enable
    localparam int CFG_LIGHT_EN_BIT = 2; // light enable
    localparam logic [7:0] CFG1_RESET = 8'h00; // value after reset
    localparam logic [7:0] TEST_RESET = 8'h00; // test regs after reset
    localparam logic [7:0] RECOVER_KEY = 8'h29; // recovery key value
    // ****************************************
    // light range scale, lux per count times 10000
    // ****************************************
    localparam logic [15:0] SCALE_LOW = 16'h0146; // 0.0326
    localparam logic [15:0] SCALE_HIGH = 16'h1464; // 0.522
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 100; // clk_sys rate
    localparam int INTEG_MS = 100; // integration window
    localparam int INTEG_CYC = INTEG_MS * 1000 * CLK_MHZ; // cycles
    localparam int COUNT_W = 24; // window counter width
    localparam int CODE_W = 12; // conversion code width
    // ****************************************
    // two-wire slave states
    // ****************************************
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK = 3'b010,
        ST_DATA = 3'b011,
        ST_SKIP = 3'b100
    } spis_state_e;
endpackage

// *** spis_top.sv ***
// sensor power and init sequencer: two-wire slave and config
//****************************************
//****************************************
`timescale 1ns/1ps
module spis_top
#(
    parameter int WINDOW_CYC = spis_pkg::INTEG_CYC
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_oe_n,
    input wire logic photo_pulse,
    output logic [7:0] cfg1_q,
    output logic [7:0] test1_q,
    output logic [7:0] test2_q,
    output logic power_down,
    output logic light_run,
    output logic [11:0] code_q,
    output logic code_valid_q,
    output logic [27:0] lux_x10k_q,
    output logic recovered_q
);
    // ****************************************
    // bus line sampling and conditions
    // ****************************************
    logic scl_q; // previous clock level
    logic sda_q; // previous data level
    wire scl_rise = scl_in & ~scl_q;
    wire scl_fall = ~scl_in & scl_q;
    wire start_c = scl_in & scl_q & sda_q & ~sda_in;
    wire stop_c = scl_in & scl_q & ~sda_q & sda_in;
    spis_pkg::spis_state_e st_q; // slave state
    spis_pkg::spis_state_e ret_q; // state after ack slot
    logic [7:0] sh_q; // receive shift register
    logic [3:0] bit_q; // bits received in the byte
    logic [1:0] byte_q; // bytes taken this transaction
    logic [7:0] idx_q; // register index byte
    logic ack_drive_q; // pull data low in ack slot
    logic [2:0] rec_q; // recovery progress
    wire [7:0] byte_in = {sh_q[6:0], sda_in};
    wire addr_hit = (byte_in[7:1] == spis_pkg::SLAVE_ADDR) & ~byte_in[0];
    wire byte_done = scl_rise & (bit_q == 4'h7);
    wire data_wr = (st_q == spis_pkg::ST_DATA) & byte_done & (byte_q == 2'h1);
    wire wr_cfg1 = data_wr & (idx_q == spis_pkg::REG_CFG1);
    wire wr_t1 = data_wr & (idx_q == spis_pkg::REG_TEST1);
    wire wr_t2 = data_wr & (idx_q == spis_pkg::REG_TEST2);
    // ****************************************
    // sampled line history
    // ****************************************
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end
    // ****************************************
    // byte receiver and ack slot
    // ****************************************
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q <= spis_pkg::ST_IDLE;
            ret_q <= spis_pkg::ST_IDLE;
            sh_q <= 8'h00;
            bit_q <= 4'h0;
            byte_q <= 2'h0;
            idx_q <= 8'h00;
            ack_drive_q <= 1'b0;
        end
        else if (start_c)
        begin
            // start or repeated start opens a transaction
            st_q <= spis_pkg::ST_ADDR;
            bit_q <= 4'h0;
            byte_q <= 2'h0;
            ack_drive_q <= 1'b0;
        end
        else if (stop_c)
        begin
            st_q <= spis_pkg::ST_IDLE;
            ack_drive_q <= 1'b0;
        end
        else
        begin
            unique case (st_q)
                spis_pkg::ST_IDLE:
                    ack_drive_q <= 1'b0;
                spis_pkg::ST_ADDR:
                    if (scl_rise)
                    begin
                        sh_q <= byte_in;
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'h7)
                        begin
                            // other addresses and reads are ignored
                            st_q <= addr_hit ? spis_pkg::ST_ACK
                                             : spis_pkg::ST_SKIP;
                            ret_q <= spis_pkg::ST_DATA;
                        end
                    end
                spis_pkg::ST_ACK:
                    if (scl_fall)
                    begin
                        // hold data low across the ninth clock
                        ack_drive_q <= ~ack_drive_q;
                        if (ack_drive_q)
                        begin
                            st_q <= ret_q;
                            bit_q <= 4'h0;
                        end
                    end
                spis_pkg::ST_DATA:
                    if (scl_rise)
                    begin
                        sh_q <= byte_in;
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'h7)
                        begin
                            // index byte then data byte
                            if (byte_q == 2'h0)
                                idx_q <= byte_in;
                            byte_q <= (byte_q == 2'h2) ? byte_q
                                                       : byte_q + 2'h1;
                            st_q <= spis_pkg::ST_ACK;
                            ret_q <= spis_pkg::ST_DATA;
                        end
                    end
                spis_pkg::ST_SKIP:
                    ack_drive_q <= 1'b0;
                default:
                    st_q <= spis_pkg::ST_IDLE;
            endcase
        end
    end
    // ****************************************
    // configuration and test registers
    // ****************************************
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg1_q <= spis_pkg::CFG1_RESET;
            test1_q <= spis_pkg::TEST_RESET;
            test2_q <= spis_pkg::TEST_RESET;
        end
        else
        begin
            if (wr_cfg1)
                cfg1_q <= byte_in;
            if (wr_t1)
                test1_q <= byte_in;
            if (wr_t2)
                test2_q <= byte_in;
        end
    end
    // ****************************************
    // recovery sequence tracker
    // ****************************************
    wire step_ok = (rec_q == 3'h0 & wr_cfg1 & byte_in == 8'h00)
        | (rec_q == 3'h1 & wr_t2 & byte_in == spis_pkg::RECOVER_KEY)
        | (rec_q == 3'h2 & wr_t1 & byte_in == 8'h00)
        | (rec_q == 3'h3 & wr_t2 & byte_in == 8'h00);
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            rec_q <= 3'h0;
        else if (step_ok)
            rec_q <= rec_q + 3'h1;
        else if (data_wr & rec_q != 3'h4)
            rec_q <= 3'h0;
    end
    assign recovered_q = (rec_q == 3'h4);
    // ****************************************
    // power state and light converter
    // ****************************************
    assign sda_oe_n = ~ack_drive_q;
    assign power_down = ~cfg1_q[spis_pkg::CFG_PROX_EN_BIT]
                      & ~cfg1_q[spis_pkg::CFG_LIGHT_EN_BIT];
    assign light_run = cfg1_q[spis_pkg::CFG_LIGHT_EN_BIT]
                     & ~cfg1_q[spis_pkg::CFG_LIGHT_IR_BIT];
    spis_light_conv #(.WINDOW_CYC(WINDOW_CYC)) u_conv
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .enable(light_run),
        .range_high(cfg1_q[spis_pkg::CFG_RANGE_BIT]),
        .photo_pulse(photo_pulse),
        .code_q(code_q),
        .code_valid_q(code_valid_q),
        .lux_x10k_q(lux_x10k_q)
    );
    // ****************************************
    // checks
    // ****************************************
    a_pd_follows_cfg: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (cfg1_q == 8'h00) |-> power_down)
        else $error("power-down missing with cleared config");
    a_zero_clears: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (wr_cfg1 && byte_in == 8'h00)
        |=> (cfg1_q == 8'h00 && power_down))
        else $error("zero write did not clear config");
    a_addr_only: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (st_q == spis_pkg::ST_ADDR && byte_done && !addr_hit && !start_c
         && !stop_c) |=> (st_q == spis_pkg::ST_SKIP))
        else $error("foreign address taken");
    a_ack_low: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        $rose(ack_drive_q) |-> (st_q == spis_pkg::ST_ACK))
        else $error("data pulled outside ack slot");
    a_idle_stop: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (stop_c && !start_c)
        |=> (st_q == spis_pkg::ST_IDLE && !ack_drive_q))
        else $error("stop not honoured");
    // scale is the range bit the converter saw at the window end
    a_range_scale: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        $rose(code_valid_q) |-> (lux_x10k_q == code_q
        * ($past(cfg1_q[spis_pkg::CFG_RANGE_BIT]) ? spis_pkg::SCALE_HIGH
        : spis_pkg::SCALE_LOW)))
        else $error("lux scale wrong");
    a_conv_off: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        !light_run |=> !code_valid_q)
        else $error("conversion while not in light mode");
    a_cfg_write: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        wr_cfg1 |=> (cfg1_q == $past(byte_in)))
        else $error("config write lost");
    c_recovered: cover property (@(posedge clk_sys) disable iff (!nrst)
        $rose(recovered_q));
    c_conv_done: cover property (@(posedge clk_sys) disable iff (!nrst)
        $rose(code_valid_q));
    c_pd_entry: cover property (@(posedge clk_sys) disable iff (!nrst)
        $rose(power_down));
endmodule

// *** spis_top_bench.sv ***
// self-checking bench for the sensor power and init sequencer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; \
    if ((got) !== (ex)) begin bad_count++; \
    $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module spis_top_bench;
    localparam int WIN = 64; // shortened integration window
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic photo_pulse = 1'b0;
    logic scl, sda_m, sda_oe_n, power_down, light_run, code_valid_q;
    logic recovered_q;
    logic [7:0] cfg1_q, test1_q, test2_q;
    logic [11:0] code_q;
    logic [27:0] lux_x10k_q;
    wire sda_bus = sda_m & sda_oe_n; // pulled-up open-drain wire
    int bad_count = 0;
    int samples_checked = 0;
    int m_cfg, m_t1, m_t2, ph_per = 4, ph_cnt = 0, run_cyc = 0;
    int steps_q[$] = '{8'h01, 8'h00, 8'h0F, 8'h29, 8'h0E, 8'h00, 8'h0F, 8'h00};
    logic [31:0] rnd = 32'h00011CFD; // seed 72957
    // ****************************************
    // clock, photodiode pulses, run counter
    // ****************************************
    always #5 clk_sys = ~clk_sys;
    // one-cycle pulses every ph_per cycles
    always @(posedge clk_sys)
    begin
        ph_cnt <= ph_cnt + 1;
        photo_pulse <= (ph_cnt % ph_per == 0);
        run_cyc <= light_run ? run_cyc + 1 : 0;
    end
    spis_host i_host (.clk_sys(clk_sys), .scl(scl), .sda_m(sda_m),
        .sda_bus(sda_bus));
    spis_top #(.WINDOW_CYC(WIN)) i_dut (.clk_sys(clk_sys), .nrst(nrst),
        .scl_in(scl), .sda_in(sda_bus), .sda_oe_n(sda_oe_n),
        .photo_pulse(photo_pulse), .cfg1_q(cfg1_q), .test1_q(test1_q),
        .test2_q(test2_q), .power_down(power_down), .light_run(light_run),
        .code_q(code_q), .code_valid_q(code_valid_q),
        .lux_x10k_q(lux_x10k_q), .recovered_q(recovered_q));
    // ****************************************
    // model and checks
    // ****************************************
    // xorshift source for register values
    function automatic logic [31:0] next_rnd(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    // registers and decoded modes against the model
    task automatic check_regs();
        `CHK("cfg1", m_cfg[7:0], cfg1_q)
        `CHK("test1", m_t1[7:0], test1_q)
        `CHK("test2", m_t2[7:0], test2_q)
        `CHK("pwrdn", !m_cfg[7] && !m_cfg[2], power_down)
        `CHK("run", m_cfg[2] && !m_cfg[0], light_run)
    endtask
    // one addressed write, model updated only if it was ours
    task automatic do_write(input logic [6:0] adr, input logic rd,
        input logic [7:0] idx, input logic [7:0] dat);
        logic [2:0] acks;
        logic ours;
        ours = (adr == 7'b1000100) && !rd;
        i_host.write_reg(adr, rd, idx, dat, acks);
        `CHK("ack", ours ? 3'b111 : 3'b000, acks)
        if (ours && idx == 8'h01)
            m_cfg = dat;
        if (ours && idx == 8'h0E)
            m_t1 = dat;
        if (ours && idx == 8'h0F)
            m_t2 = dat;
        check_regs();
    endtask
    // reset held four cycles, model back to cleared state
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        m_cfg = 0;
        m_t1 = 0;
        m_t2 = 0;
        check_regs();
        `CHK("valid", 1'b0, code_valid_q)
        `CHK("recov", 1'b0, recovered_q)
    endtask
    // bounded wait for a finished conversion, then its figures
    task automatic conv_check(input int cnt, input int scale);
        int n;
        for (n = 0; n < 4 * WIN && code_valid_q !== 1'b1; n++)
            @(posedge clk_sys);
        if (n >= 4 * WIN)
        begin
            // no conversion arrived: count it and close the run
            $display("mismatch conversion expected 1 seen 0");
            bad_count++;
            finish_test();
        end
        else
        begin
            `CHK("window", 1'b1, run_cyc >= WIN - 1 && run_cyc <= WIN + 2)
            `CHK("code", cnt[11:0], code_q)
            `CHK("lux", cnt * scale, int'(lux_x10k_q))
        end
    endtask
    // verdict and end of run
    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    initial
    begin
        do_reset();
        for (int i = 0; i < 8; i += 2)
        begin
            do_write(7'b1000100, 1'b0, steps_q[i],
                steps_q[i + 1]);
            `CHK("recov", i == 6, recovered_q)
        end
        repeat (2000) @(posedge clk_sys);
        $display("test recovery done");
        for (int i = 0; i < 10; i++)
        begin
            rnd = next_rnd(rnd);
            do_write(7'b1000100, 1'b0, 8'h01, rnd[7:0]);
            do_write(7'b1000100 ^ rnd[14:8], rnd[15], 8'h01, 8'h00);
        end
        do_write(7'b1000100, 1'b0, 8'h01, 8'h00);
        do_write(7'b1000100, 1'b0, 8'h01, 8'h80);
        $display("test config done");
        do_write(7'b1000100, 1'b0, 8'h01, 8'h04);
        conv_check(WIN / 4, 326);
        // stop the converter so the high range window starts afresh
        do_write(7'b1000100, 1'b0, 8'h01, 8'h00);
        `CHK("valid", 1'b0, code_valid_q)
        ph_per = 2;
        do_write(7'b1000100, 1'b0, 8'h01, 8'h06);
        conv_check(WIN / 2, 5220);
        do_write(7'b1000100, 1'b0, 8'h01, 8'h05);
        repeat (4) @(posedge clk_sys);
        `CHK("valid", 1'b0, code_valid_q)
        $display("test converter done");
        do_reset();
        finish_test();
    end
    // hang guard
    initial
    begin
        repeat (90000) @(posedge clk_sys);
        bad_count++;
        finish_test();
    end
endmodule
